// >>> include/emrc_pkg.sv
// Shared constants and types of the emulator run-control block
package emrc_pkg;
   // ==================================================
   // Sizes
   localparam int SB_DEPTH  = 10;
   localparam int TADDR_W   = 16;
   localparam int QUAL_W    = 7;
   localparam int PROBE_W   = 8;
   // ==================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_CFG    = 8'h04;
   localparam logic [7:0] OFS_SBADDR = 8'h08;
   localparam logic [7:0] OFS_HBADDR = 8'h0C;
   localparam logic [7:0] OFS_HBQUAL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_TRACE  = 8'h18;
   // ==================================================
   // Command register bit positions
   localparam int CB_RUN    = 0;
   localparam int CB_CONT   = 1;
   localparam int CB_SSTEP  = 2;
   localparam int CB_STOP   = 3;
   localparam int CB_ARM    = 4;
   localparam int CB_NORM   = 5;
   localparam int CB_SETSB  = 6;
   localparam int CB_CLR1   = 7;
   localparam int CB_CLRALL = 8;
   localparam int CB_MEMOK  = 9;
   localparam int CB_ERRCLR = 10;
   // Configuration fields
   localparam int CF_NXA_LSB = 0;
   localparam int CF_EXTQ    = 4;
   localparam int CF_VAR2    = 5;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [3:0] NXA_MAX = 4'h8;
   // ==================================================
   // Halt causes and run states
   typedef enum logic [3:0] {
      HC_ABORT = 4'h0, HC_HW   = 4'h1, HC_KEY   = 4'h2,
      HC_MULTI = 4'h3, HC_PAR  = 4'h4, HC_POR   = 4'h5,
      HC_PNL   = 4'h6, HC_RUNNING = 4'h7, HC_SW = 4'h8,
      HC_SS    = 4'h9, HC_STOP = 4'hA, HC_TIME  = 4'hB,
      HC_FUL   = 4'hC
   } emrc_halt_t;
   typedef enum logic [3:0] {
      ST_HALTED = 4'b0001, ST_START = 4'b0010,
      ST_RUN    = 4'b0100, ST_SSTEP = 4'b1000
   } emrc_state_t;
   // ==================================================
   // Carriers
   typedef struct packed {
      logic               valid;
      logic               fetch;
      logic [TADDR_W-1:0] addr;
      logic [QUAL_W-1:0]  qual;
   } emrc_bus_t;
   typedef struct packed {
      logic key;
      logic multi;
      logic parity;
      logic panel;
      logic timeout;
      logic full;
      logic trace_done;
   } emrc_evt_t;
endpackage

// >>> verilog/emrc_sbtab.sv
// Software breakpoint address table with registered lookup
`timescale 1ns/100ps
module emrc_sbtab import emrc_pkg::*; (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               set_i,
   input  wire logic               clr_one_i,
   input  wire logic               clr_all_i,
   input  wire logic [TADDR_W-1:0] op_addr_i,
   input  wire logic               look_i,
   input  wire logic [TADDR_W-1:0] look_addr_i,
   output logic                    hit_o,
   output logic                    err_o,
   output logic [3:0]              count_o
);
   logic [TADDR_W-1:0] addr_r [SB_DEPTH];
   logic [SB_DEPTH-1:0] vld_r, vld_nxt, op_m, lk_m;
   logic [3:0]          free_idx;
   logic                has_free, err_nxt;
   logic [3:0]          cnt_nxt;

   // ==================================================
   // Match per entry
   genvar g;
   generate
      for (g = 0; g < SB_DEPTH; g++) begin : g_ent
         assign op_m[g] = vld_r[g] && addr_r[g] == op_addr_i;
         assign lk_m[g] = vld_r[g] && addr_r[g] == look_addr_i;
      end
   endgenerate

   always_comb begin
      vld_nxt  = vld_r;
      err_nxt  = 1'b0;
      has_free = 1'b0;
      free_idx = 4'h0;
      cnt_nxt  = 4'h0;
      for (int i = SB_DEPTH - 1; i >= 0; i--) begin
         if (!vld_r[i]) begin
            has_free = 1'b1;
            free_idx = 4'(i);
         end
      end
      if (clr_all_i) begin
         vld_nxt = '0;                                     // R7
      end else if (clr_one_i) begin
         vld_nxt = vld_r & ~op_m;                          // R7
      end else if (set_i && op_m == '0) begin
         // A repeated address takes no second slot
         if (has_free) begin
            vld_nxt[free_idx] = 1'b1;                      // R4
         end else begin
            err_nxt = 1'b1;                                // R4
         end
      end
      for (int i = 0; i < SB_DEPTH; i++) begin
         cnt_nxt = cnt_nxt + {3'h0, vld_nxt[i]};
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         vld_r   <= '0;
         hit_o   <= 1'b0;
         err_o   <= 1'b0;
         count_o <= 4'h0;
      end else begin
         vld_r   <= vld_nxt;
         hit_o   <= look_i && lk_m != '0;
         err_o   <= err_nxt;
         count_o <= cnt_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (set_i && !clr_all_i && !clr_one_i && op_m == '0 && has_free) begin
         addr_r[free_idx] <= op_addr_i;
      end
   end
endmodule // emrc_sbtab

// >>> verilog/emrc_core.sv
// Emulator run control: halt, resume, alternate run and breakpoints
// Overview of operation
// R1: With no extended-address bits assigned, all eight probes are data.
// R2: Probe 0 is address LSB; first probe above is data LSB.
// R3: External qualification adds an extended data byte match to breakpoints. The code applies it to the hardware breakpoint only.
// R4: Table holds ten distinct addresses; adding an eleventh flags an error.
// R5: Reaching a table address halts the target, unless alternate run.
// R6: Run or continue-run resumes the target after a halt.
// R7: Entries are removed one by address, or all at once.
// R8: First variant in alternate run keeps running; monitor returns.
// R9: Second variant continues on hardware events, halts on soft breakpoint.
// R10: Alternate run timing equals normal except monitor memory access.
// R11: Arming takes a one-bit memory permit option, default not permitted.
// R12: Permitted memory access in alternate run briefly halts the target.
// R13: Returning to normal run leaves a running target running.
// R14: Halt cause is reported from a fixed code set.
// R15: Hardware break report keeps the sample being processed.
// R16: Stop during alternate run halts and records the stop cause.
// R17: Command-entry flag may be high while target runs in alternate.
// R18: Stop halts at once without waiting for breakpoints.
// R19: After return to normal run, next breakpoint halts the target.
// R20: Halt code holds until next run, continue or single step. A panel event while halted still reloads HC_PNL.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
module emrc_core import emrc_pkg::*; (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire emrc_bus_t          tgt_bus,
   input  wire logic [PROBE_W-1:0] probe_in,
   input  wire emrc_evt_t          evt_in,
   input  wire logic               mon_mem_req,
   output logic                    mon_mem_grant,
   output logic                    tgt_run,
   output logic                    cmd_entry,
   output logic                    hwb_event
);
   // ==================================================
   // Bus slave
   logic        ack_nxt, wr_go;
   logic [31:0] rdat_nxt, wmask, wval;
   logic [5:0]  cfg_r, cfg_nxt;
   logic [15:0] sbaddr_r, sbaddr_nxt;
   logic [23:0] hbaddr_r, hbaddr_nxt;
   logic [15:0] hbqual_r, hbqual_nxt;
   logic [31:0] trace_r, trace_nxt;
   logic [10:0] cmd;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{wb_sel_i[i]}};
      end
      ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
      wr_go   = ack_nxt && wb_we_i;
      wval    = wb_dat_i & wmask;
      cmd     = (wr_go && wb_adr_i == OFS_CMD) ? wval[10:0] : 11'h000;
   end

   // ==================================================
   // Run state
   emrc_state_t st_r, st_nxt;
   emrc_halt_t  code_r, code_nxt;
   logic        alt_r, alt_nxt, memok_r, memok_nxt;
   logic        ce_r, ce_nxt, run_nxt, gnt_nxt;
   logic        sberr_r, sberr_nxt, sb_hit, sb_err;
   logic [3:0]  sb_cnt, nxa;
   logic [7:0]  xa_mask, xdata, xaddr;
   logic        hb_hit, hb_pend, sb_pend, tr_pend, key_pend;
   logic        var2, fault, soft_ok, hb_nxt;

   always_comb begin
      nxa   = (cfg_r[CF_NXA_LSB +: 4] > NXA_MAX) ?
              NXA_MAX : cfg_r[CF_NXA_LSB +: 4];
      // Probes above address bits form data byte
      xa_mask = ~(8'hFF << nxa);                           // R2
      xaddr   = probe_in & xa_mask;                        // R2
      xdata   = probe_in >> nxa;                           // R1 R2
      hb_hit  = tgt_bus.valid
                && tgt_bus.addr == hbaddr_r[15:0]
                && xaddr == (hbaddr_r[23:16] & xa_mask)
                && tgt_bus.qual == hbqual_r[6:0]
                && (!cfg_r[CF_EXTQ] || xdata == hbqual_r[15:8]); // R3
   end

   // Table writes are refused while armed for alternate run
   assign soft_ok = !alt_r;

   emrc_sbtab u_sbtab (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .set_i       (cmd[CB_SETSB] && soft_ok),
      .clr_one_i   (cmd[CB_CLR1] && soft_ok),
      .clr_all_i   (cmd[CB_CLRALL] && soft_ok),
      .op_addr_i   (sbaddr_r),
      .look_i      (tgt_bus.valid && tgt_bus.fetch),
      .look_addr_i (tgt_bus.addr),
      .hit_o       (sb_hit),
      .err_o       (sb_err),
      .count_o     (sb_cnt)
   );

   always_comb begin
      var2     = cfg_r[CF_VAR2];
      fault    = evt_in.panel || evt_in.parity || evt_in.multi
                 || evt_in.timeout || evt_in.full;
      sb_pend  = sb_hit && (!alt_r || var2);               // R5 R9
      hb_pend  = hb_hit && !alt_r;                         // R19
      tr_pend  = evt_in.trace_done && !alt_r;
      key_pend = evt_in.key && !alt_r;
      st_nxt   = st_r;
      code_nxt = code_r;
      alt_nxt  = alt_r;
      memok_nxt = memok_r;
      ce_nxt   = ce_r;
      hb_nxt   = 1'b0;
      trace_nxt = trace_r;
      sberr_nxt = (sberr_r && !cmd[CB_ERRCLR]) || sb_err; // R4
      if (cmd[CB_ARM]) begin
         alt_nxt   = 1'b1;
         memok_nxt = cmd[CB_MEMOK];                        // R11
      end else if (cmd[CB_NORM]) begin
         alt_nxt = 1'b0;                                   // R13
      end
      case (st_r)
         ST_HALTED: begin
            ce_nxt = 1'b1;
            if (cmd[CB_RUN] || cmd[CB_CONT]) begin
               st_nxt   = ST_START;                        // R6
               code_nxt = HC_RUNNING;                      // R20
               ce_nxt   = 1'b0;
            end else if (cmd[CB_SSTEP]) begin
               st_nxt   = ST_SSTEP;
               code_nxt = HC_RUNNING;                      // R20
               ce_nxt   = 1'b0;
            end
         end
         ST_START: begin
            if (evt_in.key) begin
               st_nxt   = ST_HALTED;
               code_nxt = HC_ABORT;                        // R14
            end else begin
               st_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            st_nxt = ST_HALTED;
            if (cmd[CB_STOP]) begin
               code_nxt = HC_STOP;                         // R16 R18
            end else if (evt_in.panel) begin
               code_nxt = HC_PNL;                          // R14
            end else if (evt_in.parity) begin
               code_nxt = HC_PAR;                          // R14
            end else if (evt_in.multi) begin
               code_nxt = HC_MULTI;                        // R14
            end else if (evt_in.timeout) begin
               code_nxt = HC_TIME;                         // R14
            end else if (evt_in.full) begin
               code_nxt = HC_FUL;                          // R14
            end else if (sb_pend) begin
               code_nxt = HC_SW;                           // R5 R9
            end else if (hb_pend) begin
               code_nxt  = HC_HW;                          // R19
               hb_nxt    = 1'b1;
               trace_nxt = {probe_in, 1'b0, tgt_bus.qual,
                            tgt_bus.addr};                 // R15
            end else if (tr_pend) begin
               code_nxt = HC_HW;
            end else if (key_pend) begin
               code_nxt = HC_KEY;
            end else begin
               st_nxt = ST_RUN;
               // Armed: events only return to the monitor
               if (sb_hit || hb_hit || evt_in.trace_done
                   || evt_in.key) begin
                  ce_nxt = 1'b1;                           // R8 R17
               end else if (cmd[CB_RUN] || cmd[CB_CONT]) begin
                  ce_nxt = 1'b0;
               end
               if (hb_hit) begin
                  hb_nxt    = 1'b1;
                  trace_nxt = {probe_in, 1'b0, tgt_bus.qual,
                               tgt_bus.addr};              // R15
               end
            end
            if (st_nxt == ST_HALTED) begin
               ce_nxt = 1'b1;
            end
         end
         ST_SSTEP: begin
            if (cmd[CB_STOP]) begin
               st_nxt   = ST_HALTED;
               code_nxt = HC_STOP;                         // R18
            end else if (tgt_bus.valid && tgt_bus.fetch) begin
               st_nxt   = ST_HALTED;
               code_nxt = HC_SS;                           // R14
               ce_nxt   = 1'b1;
            end
         end
         default: begin
            st_nxt   = ST_HALTED;
            code_nxt = HC_POR;
         end
      endcase
      // Panel reset overrides the run state
      if (evt_in.panel) begin
         st_nxt   = ST_HALTED;
         code_nxt = HC_PNL;                                // R14
         ce_nxt   = 1'b1;
      end
      // Monitor memory access: free when halted, granted when armed with the memory permit bit set
      gnt_nxt = mon_mem_req && (st_nxt == ST_HALTED
                || (alt_nxt && memok_nxt));                // R11 R12
      run_nxt = (st_nxt == ST_RUN || st_nxt == ST_SSTEP)
                && !gnt_nxt;                               // R10 R12
   end

   // ==================================================
   // Register writes and reads
   always_comb begin
      cfg_nxt    = cfg_r;
      sbaddr_nxt = sbaddr_r;
      hbaddr_nxt = hbaddr_r;
      hbqual_nxt = hbqual_r;
      rdat_nxt   = 32'h0000_0000;
      if (wr_go) begin
         case (wb_adr_i)
            OFS_CFG:    cfg_nxt = (cfg_r & ~wmask[5:0]) | wval[5:0];
            OFS_SBADDR: sbaddr_nxt = (sbaddr_r & ~wmask[15:0])
                                     | wval[15:0];
            OFS_HBADDR: hbaddr_nxt = (hbaddr_r & ~wmask[23:0])
                                     | wval[23:0];
            OFS_HBQUAL: hbqual_nxt = (hbqual_r & ~wmask[15:0])
                                     | wval[15:0];
            default:    cfg_nxt = cfg_r;
         endcase
      end
      case (wb_adr_i)
         OFS_CFG:    rdat_nxt = {26'h000_0000, cfg_r};
         OFS_SBADDR: rdat_nxt = {16'h0000, sbaddr_r};
         OFS_HBADDR: rdat_nxt = {8'h00, hbaddr_r};
         OFS_HBQUAL: rdat_nxt = {16'h0000, hbqual_r};
         OFS_STATUS: rdat_nxt = {19'h0_0000, sberr_r, sb_cnt,
                                 ce_r, memok_r, alt_r, tgt_run,
                                 code_r};                  // R14
         OFS_TRACE:  rdat_nxt = trace_r;                   // R15
         default:    rdat_nxt = 32'h0000_0000;
      endcase
      if (!ack_nxt || wb_we_i) begin
         rdat_nxt = 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0000_0000;
         cfg_r         <= CFG_RST;
         sbaddr_r      <= 16'h0000;
         hbaddr_r      <= 24'h00_0000;
         hbqual_r      <= 16'h0000;
         trace_r       <= 32'h0000_0000;
         st_r          <= ST_HALTED;
         code_r        <= HC_POR;
         alt_r         <= 1'b0;
         memok_r       <= 1'b0;
         ce_r          <= 1'b1;
         sberr_r       <= 1'b0;
         tgt_run       <= 1'b0;
         mon_mem_grant <= 1'b0;
         cmd_entry     <= 1'b1;
         hwb_event     <= 1'b0;
      end else begin
         wb_ack_o      <= ack_nxt;
         wb_dat_o      <= rdat_nxt;
         cfg_r         <= cfg_nxt;
         sbaddr_r      <= sbaddr_nxt;
         hbaddr_r      <= hbaddr_nxt;
         hbqual_r      <= hbqual_nxt;
         trace_r       <= trace_nxt;
         st_r          <= st_nxt;
         code_r        <= code_nxt;
         alt_r         <= alt_nxt;
         memok_r       <= memok_nxt;
         ce_r          <= ce_nxt;
         sberr_r       <= sberr_nxt;
         tgt_run       <= run_nxt;
         mon_mem_grant <= gnt_nxt;
         cmd_entry     <= ce_nxt;
         hwb_event     <= hb_nxt;
      end
   end

   // ==================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_stop;
      st_r == ST_RUN && cmd[CB_STOP] |=> st_r == ST_HALTED
         && code_r == HC_STOP && !tgt_run;
   endproperty
   a_stop: assert property (p_stop) else $error("stop ignored"); // R16

   property p_sb_norm;
      st_r == ST_RUN && sb_hit && !alt_r |=> st_r == ST_HALTED;
   endproperty
   a_sb_norm: assert property (p_sb_norm) else $error("no sb halt"); // R5

   property p_alt_keep;
      st_r == ST_RUN && alt_r && !var2 && !fault && !cmd[CB_STOP]
         && (sb_hit || hb_hit) |=> st_r == ST_RUN && cmd_entry
         && tgt_run == !mon_mem_grant;
   endproperty
   a_alt_keep: assert property (p_alt_keep) else $error("alt stop"); // R8

   property p_var2;
      st_r == ST_RUN && var2 && sb_hit && !fault && !cmd[CB_STOP]
         |=> code_r == HC_SW && st_r == ST_HALTED;
   endproperty
   a_var2: assert property (p_var2) else $error("var2 sb"); // R9

   property p_resume;
      st_r == ST_HALTED && cmd[CB_RUN] && !evt_in.panel
         |=> st_r == ST_START && code_r == HC_RUNNING;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume"); // R6

   property p_hold;
      st_r == ST_HALTED && $past(st_r) == ST_HALTED
         && !$past(evt_in.panel) |-> $stable(code_r);
   endproperty
   a_hold: assert property (p_hold) else $error("code moved"); // R20

   property p_memgnt;
      st_r == ST_RUN && alt_r && memok_r && mon_mem_req && !fault
         && !cmd[CB_STOP] && !cmd[CB_NORM] && !cmd[CB_ARM]
         |=> mon_mem_grant && !tgt_run;
   endproperty
   a_memgnt: assert property (p_memgnt) else $error("mem grant"); // R12

   property p_sb_cnt;
      sb_cnt <= 4'(SB_DEPTH) && (!sb_err || sb_cnt == 4'(SB_DEPTH));
   endproperty
   a_sb_cnt: assert property (p_sb_cnt) else $error("table size"); // R4

   property p_hw_trace;
      st_r == ST_RUN && hb_hit && !alt_r && !fault && !sb_pend
         && !cmd[CB_STOP] |=> code_r == HC_HW && hwb_event
         && trace_r[15:0] == $past(tgt_bus.addr);
   endproperty
   a_hw_trace: assert property (p_hw_trace) else $error("hw break"); // R15
endmodule // emrc_core

// >>> tb/emrc_tgt_model.sv
// Target core model: instruction fetch stream while the core may run
`timescale 1ns/100ps
module emrc_tgt_model import emrc_pkg::*; (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               tgt_run,
   input  wire logic               load,
   input  wire logic               slow,
   input  wire logic [TADDR_W-1:0] start_addr,
   input  wire logic [QUAL_W-1:0]  qual_v,
   output emrc_bus_t               tgt_bus
);
   // ==================================================
   // Program counter; slow mode fetches every other cycle
   logic [TADDR_W-1:0] pc_r;
   logic               ph_r;
   logic               go;
   assign go = tgt_run & ~(slow & ph_r);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pc_r <= 16'h0000;
         ph_r <= 1'b0;
      end else begin
         ph_r <= ~ph_r;
         if (load) begin
            pc_r <= start_addr;
         end else if (go) begin
            pc_r <= pc_r + 16'h0001;
         end
      end
   end
   // Idle bus shows inverted values so a stale copy never matches
   assign tgt_bus = go ? {1'b1, 1'b1, pc_r, qual_v}
                       : {1'b0, 1'b0, ~pc_r, ~qual_v};
endmodule // emrc_tgt_model

// >>> tb/tb.sv
// Testbench: run control driven over the register bus and a target model
`timescale 1ns/100ps
module tb
   import emrc_pkg::*;
   ;
   // ==================================================
   // Signals
   logic               sys_clk = 1'b0;
   logic               rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]         wb_adr_i;
   logic [3:0]         wb_sel_i;
   logic [31:0]        wb_dat_i, wb_dat_o, lf;
   logic               mon_mem_req, mon_mem_grant, tgt_run, cmd_entry;
   logic               hwb_event, ld, slow;
   emrc_bus_t          tgt_bus;
   emrc_evt_t          evt_in;
   logic [PROBE_W-1:0] probe_in, pr;
   logic [TADDR_W-1:0] start_a, sa, ha;
   logic [TADDR_W-1:0] sba [11];
   logic [QUAL_W-1:0]  qual_v;
   int                 fails, checked, i, nb;
   typedef struct packed {logic [31:0] d; logic [31:0] m;} emrc_exp_t;
   emrc_exp_t          exp_q [$];
   emrc_exp_t          ex;
   emrc_halt_t         cd [7];
   always #4 sys_clk = ~sys_clk;
   emrc_core emrc_core_inst (.sys_clk(sys_clk), .rstn(rstn),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tgt_bus(tgt_bus),
      .probe_in(probe_in), .evt_in(evt_in), .mon_mem_req(mon_mem_req),
      .mon_mem_grant(mon_mem_grant), .tgt_run(tgt_run),
      .cmd_entry(cmd_entry), .hwb_event(hwb_event));
   emrc_tgt_model emrc_tgt_model_inst (.sys_clk(sys_clk), .rstn(rstn),
      .tgt_run(tgt_run), .load(ld), .slow(slow), .start_addr(start_a),
      .qual_v(qual_v), .tgt_bus(tgt_bus));
   // ==================================================
   // Helpers
   function automatic logic [31:0] c(input int b);
      return 32'h0000_0001 << b;
   endfunction
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Status: err, count, flags, code
   function automatic logic [31:0] st(input logic [3:0] h, f, n,
                                      input logic e);
      return {19'h0_0000, e, n, f, h};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic close_out();
      $display("Counts: checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Hold request until ack sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (n >= 40) begin
         fails++;
         close_out();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      exp_q.push_back('{e, m});
      xfer(1'b0, a, '0);
   endtask
   task automatic cmd(input logic [31:0] v);
      wr(OFS_CMD, v);
   endtask
   task automatic set_sb(input logic [15:0] a);
      wr(OFS_SBADDR, 32'(a));
      cmd(c(CB_SETSB));
   endtask
   task automatic wrun(input logic v);
      int n = 0;
      while (tgt_run !== v && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(tgt_run), 32'(v));
   endtask
   task automatic go(input logic [15:0] a);
      @(posedge sys_clk);
      ld      <= 1'b1;
      start_a <= a;
      @(posedge sys_clk);
      ld      <= 1'b0;
      cmd(c(CB_RUN));
      wrun(1'b1);
   endtask
   // Read data judged at ack
   always @(posedge sys_clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         chk(wb_dat_o & ex.m, ex.d & ex.m);
      end
   end
   // Hang limit
   initial begin
      #800000;
      fails++;
      close_out();
   end
   // ==================================================
   // Main sequence
   initial begin
      cd = '{HC_KEY, HC_MULTI, HC_PAR, HC_PNL, HC_TIME, HC_FUL, HC_HW};
      {rstn, wb_cyc_i, wb_stb_i, wb_we_i, ld, slow, mon_mem_req} = 7'h00;
      {wb_adr_i, wb_dat_i, start_a, probe_in} = '0;
      wb_sel_i = 4'hF;
      evt_in = '0;
      qual_v = 7'h55;
      lf = 32'h0e81_5e2e;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(OFS_STATUS, st(HC_POR, 4'h8, 4'h0, 1'b0), 32'h0000_1FFF);
      for (i = 0; i < 11; i++) begin
         lf = nx(lf);
         sba[i] = {lf[11:0], i[3:0]};
         if (i < 10) set_sb(sba[i]);
      end
      set_sb(sba[3]);
      rd(OFS_STATUS, st(4'h0, 4'h0, 4'hA, 1'b0), 32'h0000_1F00);
      set_sb(sba[10]);
      rd(OFS_STATUS, st(4'h0, 4'h0, 4'hA, 1'b1), 32'h0000_1F00);
      wr(OFS_SBADDR, 32'(sba[5]));
      cmd(c(CB_CLR1));
      rd(OFS_STATUS, st(4'h0, 4'h0, 4'h9, 1'b0), 32'h0000_0F00);
      cmd(c(CB_CLRALL) | c(CB_ERRCLR));
      rd(OFS_STATUS, st(4'h0, 4'h0, 4'h0, 1'b0), 32'h0000_1F00);
      $display("Test done: breakpoint table");
      sa = sba[2];
      set_sb(sa);
      go(sa - 16'h0006);
      wrun(1'b0);
      rd(OFS_STATUS, st(HC_SW, 4'h8, 4'h1, 1'b0), 32'h0000_0FFF);
      cmd(c(CB_CONT));
      wrun(1'b1);
      rd(OFS_STATUS, st(4'h0, 4'h1, 4'h0, 1'b0), 32'h0000_0090);
      cmd(c(CB_STOP));
      @(posedge sys_clk);
      chk(32'(tgt_run), 32'h0000_0000);
      $display("Test done: soft halt");
      cmd(c(CB_ARM) | c(CB_MEMOK));
      rd(OFS_STATUS, st(4'h0, 4'h6, 4'h0, 1'b0), 32'h0000_0060);
      slow <= 1'b1;
      go(sa - 16'h0006);
      repeat (30) @(posedge sys_clk);
      rd(OFS_STATUS, st(4'h0, 4'h9, 4'h0, 1'b0), 32'h0000_0090);
      mon_mem_req <= 1'b1;
      for (nb = 0; nb < 50 && mon_mem_grant !== 1'b1; nb++) begin
         @(posedge sys_clk);
      end
      chk(32'({mon_mem_grant, tgt_run}), 32'h0000_0002);
      mon_mem_req <= 1'b0;
      wrun(1'b1);
      cmd(c(CB_STOP));
      wrun(1'b0);
      repeat (20) @(posedge sys_clk);
      rd(OFS_STATUS, st(HC_STOP, 4'hE, 4'h0, 1'b0), 32'h0000_00FF);
      slow <= 1'b0;
      go(sa - 16'h0028);
      cmd(c(CB_NORM));
      chk(32'(tgt_run), 32'h0000_0001);
      wrun(1'b0);
      rd(OFS_STATUS, st(HC_SW, 4'h0, 4'h0, 1'b0), 32'h0000_002F);
      wr(OFS_CFG, c(CF_VAR2));
      cmd(c(CB_ARM));
      go(sa - 16'h0006);
      wrun(1'b0);
      rd(OFS_STATUS, st(HC_SW, 4'h2, 4'h0, 1'b0), 32'h0000_002F);
      cmd(c(CB_NORM));
      $display("Test done: alternate run");
      lf = nx(lf);
      pr = lf[7:0];
      ha = sa ^ 16'h4000;
      for (i = 0; i < 2; i++) begin
         nb = i * 3;
         wr(OFS_CFG, c(CF_EXTQ) | 32'(nb));
         wr(OFS_HBADDR, {8'h00, pr & ~(8'hFF << nb), ha});
         wr(OFS_HBQUAL, {16'h0000, pr >> nb, 1'b0, qual_v});
         probe_in <= pr ^ 8'h80;
         go(ha - 16'h0006);
         repeat (20) @(posedge sys_clk);
         chk(32'(tgt_run), 32'h0000_0001);
         cmd(c(CB_STOP));
         wrun(1'b0);
         probe_in <= pr;
         go(ha - 16'h0006);
         wrun(1'b0);
         rd(OFS_STATUS, st(HC_HW, 4'h0, 4'h0, 1'b0), 32'h0000_000F);
         rd(OFS_TRACE, {pr, 1'b0, qual_v, ha}, 32'hFF7F_FFFF);
      end
      $display("Test done: hw break");
      wr(OFS_CFG, 32'h0000_0000);
      for (i = 0; i < 7; i++) begin
         go(sa + 16'h0100);
         evt_in <= emrc_evt_t'(7'h40 >> i);
         @(posedge sys_clk);
         evt_in <= '0;
         wrun(1'b0);
         rd(OFS_STATUS, {28'h000_0000, cd[i]}, 32'h0000_000F);
      end
      cmd(c(CB_SSTEP));
      repeat (10) @(posedge sys_clk);
      rd(OFS_STATUS, {28'h000_0000, HC_SS}, 32'h0000_000F);
      $display("Test done: halt causes");
      close_out();
   end
endmodule // tb
